// >>> rtl/fsps_top.sv
// Operation
// - three-operand subtract writes first source minus second source, as floats
// - each source is an extended register 0-7 or indirect memory, disp 0/1/index
// - destination is always an extended register 0-7, never memory
// - below_zero_flag set on negative result, cleared otherwise
// - result_null_flag set on zero result; borrow_flag left unchanged
// - overflow sets magnitude_too_big_flag else clears; latched_overflow_flag only sets
// - underflow sets underflow_flag else clears; sticky_underflow_flag only sets
// - saturation_mode_bit has no effect on the subtract result
// - parallel form: memory minus register into register, plus float store
// - parallel form reads all registers at cycle start, writes at cycle end
// - store of a register the subtract writes uses the old value
// - memory source is read before the store writes the same location
// - parallel form: registers 0-7, memory operands indirect with disp 0/1/index
`timescale 1ns/1ps
`include "fsps_consts.svh"

module fsps_top #(
    parameter int DMEM_DEPTH = 16,
    parameter int NUM_EXT = 8
) (
    input wire logic pclk, // processor clock, 20 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 = write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output fsps_pkg::fsps_flags_t status_flags // current status flags
);
    import fsps_pkg::*;

    localparam int MAW = $clog2(DMEM_DEPTH);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fsps_fp40_t ext_q [NUM_EXT];
    logic [31:0] dmem_q [DMEM_DEPTH];
    logic [23:0] aux_q [8];
    logic [23:0] idx0_q;
    logic [23:0] idx1_q;
    logic sat_mode_q;
    fsps_cmd_t cmd_q;
    fsps_flags_t flags_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic addr_mapped(input logic [11:0] a);
        logic ok;
        ok = 1'b0;
        if (a == `FSPS_OFS_CMD || a == `FSPS_OFS_STATUS || a == `FSPS_OFS_MODE) begin
            ok = 1'b1;
        end
        if (a == `FSPS_OFS_IDX0 || a == `FSPS_OFS_IDX1) begin
            ok = 1'b1;
        end
        if (a >= `FSPS_OFS_AUX_BASE && a < `FSPS_OFS_AUX_BASE + 12'h020) begin
            ok = 1'b1;
        end
        if (a >= `FSPS_OFS_EXT_BASE && a < `FSPS_OFS_EXT_BASE + 12'(NUM_EXT * 8)) begin
            ok = 1'b1;
        end
        if (a >= `FSPS_OFS_DMEM_BASE && a < `FSPS_OFS_DMEM_BASE + 12'(DMEM_DEPTH * 4)) begin
            ok = 1'b1;
        end
        return ok & (a[1:0] == 2'b00);
    endfunction

    // indirect address: auxiliary register plus displacement, no pointer update
    function automatic logic [MAW-1:0] eff_addr(input logic [2:0] aux, input fsps_disp_t d);
        logic [23:0] ofs;
        logic [23:0] sum;
        ofs = 24'h000000;
        unique case (d)
            DISP_ZERO: ofs = 24'h000000;
            DISP_ONE: ofs = 24'h000001;
            DISP_IDX0: ofs = idx0_q;
            DISP_IDX1: ofs = idx1_q;
        endcase
        sum = aux_q[aux] + ofs;
        return sum[MAW-1:0];
    endfunction

    // memory holds short floats: 8-bit exponent over 24-bit mantissa
    function automatic fsps_fp40_t fetch(input logic ind, input logic [2:0] sel,
                                         input fsps_disp_t d);
        logic [31:0] w;
        fsps_fp40_t f;
        w = dmem_q[eff_addr(sel, d)];
        if (ind) begin
            f = {w[31:24], w[23:0], 8'h00};
        end else begin
            f = ext_q[sel];
        end
        return f;
    endfunction

    // difference a - b; low bits beyond the significand are truncated
    function automatic fsps_sub_res_t fp_sub(input fsps_fp40_t a, input fsps_fp40_t b);
        logic signed [35:0] sa;
        logic signed [35:0] sb;
        logic signed [35:0] diff;
        logic signed [35:0] norm;
        logic signed [9:0] ea;
        logic signed [9:0] eb;
        logic signed [9:0] emax;
        logic signed [9:0] dexp;
        logic signed [10:0] eres;
        logic signed [6:0] p;
        fsps_sub_res_t r;
        ea = 10'(signed'(a.exp));
        eb = 10'(signed'(b.exp));
        sa = (a.exp == `FSPS_EXP_ZERO) ? 36'sd0
            : 36'(signed'({a.man[31], ~a.man[31], a.man[30:0]}));
        sb = (b.exp == `FSPS_EXP_ZERO) ? 36'sd0
            : 36'(signed'({b.man[31], ~b.man[31], b.man[30:0]}));
        emax = (ea > eb) ? ea : eb;
        if (ea > eb) begin
            dexp = ea - eb;
            sb = (dexp > 10'sd35) ? (sb >>> 35) : (sb >>> dexp);
        end else begin
            dexp = eb - ea;
            sa = (dexp > 10'sd35) ? (sa >>> 35) : (sa >>> dexp);
        end
        diff = sa - sb;
        p = -7'sd1;
        for (int i = 0; i < 35; i++) begin
            if (diff[i] != diff[35]) begin
                p = 7'(i);
            end
        end
        if (p > 7'sd31) begin
            norm = diff >>> (p - 7'sd31);
        end else begin
            norm = diff <<< (7'sd31 - p);
        end
        eres = 11'(emax) + 11'(p) - 11'sd31;
        r.val = {eres[7:0], norm[32], norm[30:0]};
        r.n = norm[32];
        r.z = 1'b0;
        r.v = 1'b0;
        r.unf = 1'b0;
        if (diff == 36'sd0) begin
            r.val = {`FSPS_EXP_ZERO, 32'h00000000};
            r.n = 1'b0;
            r.z = 1'b1;
        end else if (eres > 11'sd127) begin
            // overflow always saturates, whatever the saturation mode says
            r.val.exp = `FSPS_EXP_MAX;
            r.val.man = norm[32] ? `FSPS_MAN_NEG_MAX : `FSPS_MAN_POS_MAX;
            r.v = 1'b1;
        end else if (eres < -11'sd127) begin
            r.val = {`FSPS_EXP_ZERO, 32'h00000000};
            r.n = 1'b0;
            r.z = 1'b1;
            r.unf = 1'b1;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // apb access phase and instruction issue
    // ----------------------------------------------------------------
    logic acc_done;
    logic wr_done;
    logic exec;
    fsps_cmd_t icmd;
    fsps_fp40_t op_a;
    fsps_fp40_t op_b;
    fsps_sub_res_t res;
    logic [MAW-1:0] st_addr;
    logic [31:0] st_word;

    assign acc_done = psel & penable & pready_q;
    assign wr_done = acc_done & pwrite & addr_mapped(paddr);
    assign exec = wr_done & (paddr == `FSPS_OFS_CMD);
    assign icmd = fsps_cmd_t'(pwdata);

    // all operands come from pre-edge state; results land on the same edge
    always_comb begin
        if (icmd.par) begin
            op_a = fetch(1'b1, icmd.s2_sel, icmd.s2_disp);
            op_b = fetch(1'b0, icmd.s1_sel, icmd.s1_disp);
        end else begin
            op_a = fetch(icmd.s1_ind, icmd.s1_sel, icmd.s1_disp);
            op_b = fetch(icmd.s2_ind, icmd.s2_sel, icmd.s2_disp);
        end
        res = fp_sub(op_a, op_b);
        st_addr = eff_addr(icmd.st_aux, icmd.st_disp);
        st_word = {ext_q[icmd.src3].exp, ext_q[icmd.src3].man[31:8]};
    end

    // ----------------------------------------------------------------
    // extended register file
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
            localparam logic [11:0] EXP_OFS = `FSPS_OFS_EXT_BASE + 12'(g * 8);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ext_q[g] <= {`FSPS_EXP_ZERO, `FSPS_RST_WORD};
                end else if (exec && icmd.dst == 3'(g)) begin
                    ext_q[g] <= res.val;
                end else if (wr_done && paddr == EXP_OFS) begin
                    ext_q[g].exp <= pwdata[7:0];
                end else if (wr_done && paddr == EXP_OFS + 12'h004) begin
                    ext_q[g].man <= pwdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // data memory
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < DMEM_DEPTH; g++) begin : g_mem
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dmem_q[g] <= `FSPS_RST_WORD;
                end else if (exec && icmd.par && st_addr == MAW'(g)) begin
                    dmem_q[g] <= st_word;
                end else if (wr_done && paddr == `FSPS_OFS_DMEM_BASE + 12'(g * 4)) begin
                    dmem_q[g] <= pwdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // address and index registers
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < 8; g++) begin : g_aux
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    aux_q[g] <= 24'h000000;
                end else if (wr_done && paddr == `FSPS_OFS_AUX_BASE + 12'(g * 4)) begin
                    aux_q[g] <= pwdata[23:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx0_q <= 24'h000000;
            idx1_q <= 24'h000000;
        end else if (wr_done && paddr == `FSPS_OFS_IDX0) begin
            idx0_q <= pwdata[23:0];
        end else if (wr_done && paddr == `FSPS_OFS_IDX1) begin
            idx1_q <= pwdata[23:0];
        end
    end

    // ----------------------------------------------------------------
    // mode and last instruction
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_mode_q <= 1'b0;
        end else if (wr_done && paddr == `FSPS_OFS_MODE) begin
            sat_mode_q <= pwdata[`FSPS_MODE_SAT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= fsps_cmd_t'(`FSPS_RST_WORD);
        end else if (exec) begin
            cmd_q <= icmd;
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `FSPS_RST_FLAGS;
        end else if (exec) begin
            flags_q.below_zero_flag <= res.n;
            flags_q.result_null_flag <= res.z;
            flags_q.magnitude_too_big_flag <= res.v;
            flags_q.latched_overflow_flag <= flags_q.latched_overflow_flag | res.v;
            flags_q.underflow_flag <= res.unf;
            flags_q.sticky_underflow_flag <= flags_q.sticky_underflow_flag | res.unf;
        end else if (wr_done && paddr == `FSPS_OFS_STATUS) begin
            flags_q <= pwdata[6:0];
        end
    end

    // ----------------------------------------------------------------
    // apb slave: one wait-free access phase, read data captured in setup
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `FSPS_RST_WORD;
        end else begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~addr_mapped(paddr);
            prdata_q <= `FSPS_RST_WORD;
            if (psel && !penable && !pwrite && addr_mapped(paddr)) begin
                if (paddr == `FSPS_OFS_CMD) begin
                    prdata_q <= cmd_q;
                end else if (paddr == `FSPS_OFS_STATUS) begin
                    prdata_q <= {25'h0000000, flags_q};
                end else if (paddr == `FSPS_OFS_MODE) begin
                    prdata_q <= {31'h00000000, sat_mode_q};
                end else if (paddr == `FSPS_OFS_IDX0) begin
                    prdata_q <= {8'h00, idx0_q};
                end else if (paddr == `FSPS_OFS_IDX1) begin
                    prdata_q <= {8'h00, idx1_q};
                end else if (paddr < `FSPS_OFS_EXT_BASE) begin
                    prdata_q <= {8'h00, aux_q[paddr[4:2]]};
                end else if (paddr < `FSPS_OFS_DMEM_BASE) begin
                    prdata_q <= paddr[2] ? ext_q[paddr[5:3]].man
                        : {24'h000000, ext_q[paddr[5:3]].exp};
                end else begin
                    prdata_q <= dmem_q[paddr[MAW+1:2]];
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign status_flags = flags_q;

endmodule

// >>> rtl/fsps_consts.svh
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FSPS_OFS_CMD 12'h000
`define FSPS_OFS_STATUS 12'h004
`define FSPS_OFS_MODE 12'h008
`define FSPS_OFS_IDX0 12'h010
`define FSPS_OFS_IDX1 12'h014
`define FSPS_OFS_AUX_BASE 12'h020
`define FSPS_OFS_EXT_BASE 12'h040
`define FSPS_OFS_DMEM_BASE 12'h100

// ----------------------------------------------------------------
// field positions and float format
// ----------------------------------------------------------------
`define FSPS_MODE_SAT_BIT 0
`define FSPS_EXP_ZERO 8'h80
`define FSPS_EXP_MAX 8'h7F
`define FSPS_MAN_POS_MAX 32'h7FFFFFFF
`define FSPS_MAN_NEG_MAX 32'h80000000

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FSPS_RST_WORD 32'h00000000
`define FSPS_RST_FLAGS 7'h00

`endif

// >>> rtl/fsps_pkg.sv
package fsps_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DISP_ZERO = 2'b00,
        DISP_ONE = 2'b01,
        DISP_IDX0 = 2'b10,
        DISP_IDX1 = 2'b11
    } fsps_disp_t;

    typedef struct packed {
        logic [7:0] exp;
        logic [31:0] man;
    } fsps_fp40_t;

    typedef struct packed {
        logic sticky_underflow_flag;
        logic latched_overflow_flag;
        logic underflow_flag;
        logic below_zero_flag;
        logic result_null_flag;
        logic magnitude_too_big_flag;
        logic borrow_flag;
    } fsps_flags_t;

    typedef struct packed {
        logic [7:0] rsvd;
        logic par;
        logic [2:0] dst;
        logic s1_ind;
        logic [2:0] s1_sel;
        fsps_disp_t s1_disp;
        logic s2_ind;
        logic [2:0] s2_sel;
        fsps_disp_t s2_disp;
        logic [2:0] src3;
        logic [2:0] st_aux;
        fsps_disp_t st_disp;
    } fsps_cmd_t;

    typedef struct packed {
        fsps_fp40_t val;
        logic n;
        logic z;
        logic v;
        logic unf;
    } fsps_sub_res_t;

endpackage

// >>> dv/fsps_top_properties.sv
`timescale 1ns/1ps
// ----
// apb timing and status flag checks
// ----
module fsps_top_properties (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // wdata
    input wire logic [31:0] prdata, // rdata
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire fsps_pkg::fsps_flags_t status_flags // flags
);
    import fsps_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence cmd_s;
        psel && penable && pready && pwrite && paddr == 12'h000;
    endsequence
    chk_ready_next: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held");
    // flags may only move on the edge that completes a write
    chk_flags_cause: assert property ($changed(status_flags) |-> $past(pready && pwrite))
        else $error("flags changed without write");
    chk_borrow_kept: assert property (cmd_s |=> $stable(status_flags.borrow_flag))
        else $error("borrow changed");
    chk_ovf_kept: assert property (cmd_s |=> !$fell(status_flags.latched_overflow_flag))
        else $error("latched overflow fell");
    chk_unf_kept: assert property (cmd_s |=> !$fell(status_flags.sticky_underflow_flag))
        else $error("sticky underflow fell");
    chk_unf_zero: assert property (cmd_s ##1 status_flags.underflow_flag |->
        status_flags.result_null_flag && status_flags.sticky_underflow_flag)
        else $error("underflow without zero");
    chk_sign_zero: assert property (cmd_s |=>
        !(status_flags.below_zero_flag && status_flags.result_null_flag))
        else $error("negative and zero");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside access");
    chk_status_write: assert property (psel && penable && pready && pwrite
        && paddr == 12'h004 |=> status_flags == $past(pwdata[6:0]))
        else $error("status write lost");
endmodule

bind fsps_top fsps_top_properties i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status_flags(status_flags));

// >>> dv/fsps_apb_master.sv
`timescale 1ns/1ps
// ----
// processor side: apb master issuing commands
// ----
module fsps_apb_master (
    input wire logic pclk, // clock
    input wire logic pready, // ready
    input wire logic [31:0] prdata, // rdata
    input wire logic pslverr, // error
    output logic psel, // select
    output logic penable, // access
    output logic pwrite, // direction
    output logic [11:0] paddr, // address
    output logic [31:0] pwdata, // wdata
    output logic hung // no answer in bound
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hung = 1'b0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready) break;
        end
        if (n == 16) hung <= 1'b1;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines carry junk so nothing leans on stale values
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// >>> dv/test_fsps_top.sv
`timescale 1ns/1ps
module test_fsps_top;
    import fsps_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, hung, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, t;
    fsps_flags_t status_flags;
    fsps_cmd_t c;
    logic [6:0] fl;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 32'h3261;
    int ar[8], ir[2];
    real rg[8], mem[16], s1, s2, res;

    always #25 pclk = ~pclk;

    fsps_top #(.DMEM_DEPTH(16), .NUM_EXT(8)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_flags(status_flags));
    fsps_apb_master i_apb (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .hung(hung));

    // ----
    // model helpers
    // ----
    function automatic logic [39:0] enc(input real r, output logic o, output logic u);
        real f;
        int x;
        f = r;
        x = 0;
        o = 1'b0;
        u = 1'b0;
        if (r == 0.0) return 40'h80_0000_0000;
        while (f >= 2.0 || f < -2.0) begin
            f = f / 2.0;
            x++;
        end
        while ((f > 0.0 && f < 1.0) || (f < 0.0 && f >= -1.0)) begin
            f = f * 2.0;
            x--;
        end
        o = x > 127;
        u = x < -127;
        if (o) return r > 0.0 ? 40'h7F_7FFF_FFFF : 40'h7F_8000_0000;
        if (u) return 40'h80_0000_0000;
        // negative mantissas are two's complement, hence the +3 offset
        return {x[7:0], 32'(longint'((f > 0.0 ? f - 1.0 : f + 3.0) * 2.0 ** 31))};
    endfunction
    function automatic int adr(input int aux, input fsps_disp_t d);
        int k = d == DISP_ZERO ? 0 : d == DISP_ONE ? 1 : ir[d[0]];
        return (ar[aux] + k) & 15;
    endfunction
    task automatic chk(input logic [39:0] seen, input logic [39:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_apb.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdw(input logic [11:0] a);
        i_apb.xfer(1'b0, a, 32'h0, rd, err);
    endtask
    task automatic put_reg(input int n, input real r);
        logic [39:0] w;
        logic o, u;
        rg[n] = r;
        w = enc(r, o, u);
        wr(12'h040 + 12'(8 * n), {24'h0, w[39:32]});
        wr(12'h044 + 12'(8 * n), w[31:0]);
    endtask
    task automatic put_mem(input int i, input real r);
        logic [39:0] w;
        logic o, u;
        mem[i] = r;
        w = enc(r, o, u);
        wr(12'h100 + 12'(4 * i), {w[39:32], w[31:8]});
    endtask
    task automatic run(input fsps_cmd_t k);
        logic [39:0] w;
        logic o, u;
        if (k.par) begin
            s1 = mem[adr(k.s2_sel, k.s2_disp)];
            s2 = rg[k.s1_sel];
            mem[adr(k.st_aux, k.st_disp)] = rg[k.src3];
        end else begin
            s1 = k.s1_ind ? mem[adr(k.s1_sel, k.s1_disp)] : rg[k.s1_sel];
            s2 = k.s2_ind ? mem[adr(k.s2_sel, k.s2_disp)] : rg[k.s2_sel];
        end
        res = s1 - s2;
        w = enc(res, o, u);
        rg[k.dst] = u ? 0.0 : res;
        fl = {fl[6] | u, fl[5] | o, u, !u && res < 0.0, u || res == 0.0, o, fl[0]};
        wr(12'h000, k);
        rdw(12'h000);
        chk({8'h0, rd}, {8'h0, k});
        rdw(12'h004);
        chk({8'h0, rd}, {33'h0, fl});
        rdw(12'h040 + 12'(8 * k.dst));
        t = rd;
        rdw(12'h044 + 12'(8 * k.dst));
        chk({t[7:0], rd}, w);
        chk({33'h0, status_flags}, {33'h0, fl});
        if (k.par) begin
            w = enc(mem[adr(k.st_aux, k.st_disp)], o, u);
            rdw(12'h100 + 12'(4 * adr(k.st_aux, k.st_disp)));
            chk({8'h0, rd}, {8'h0, w[39:32], w[31:8]});
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge hung) begin
        fail_count++;
        end_sim();
    end

    // ----
    // main sequence
    // ----
    initial begin
        fl = 7'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdw(12'h040);
        chk({32'h0, rd[7:0]}, 40'h80);
        chk({33'h0, status_flags}, 40'h0);
        rdw(12'h00C);
        chk({39'h0, err}, 40'h1);
        wr(12'h004, 32'h1);
        fl[0] = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ar[i] = $random(seed) & 32'hFFFFFF;
            wr(12'h020 + 12'(4 * i), ar[i]);
            rdw(12'h020 + 12'(4 * i));
            chk({8'h0, rd}, 40'(ar[i]));
            put_reg(i, $random(seed) % 1000);
        end
        for (int i = 0; i < 2; i++) begin
            ir[i] = $random(seed) & 32'hFFFFFF;
            wr(12'h010 + 12'(4 * i), ir[i]);
            rdw(12'h010 + 12'(4 * i));
            chk({8'h0, rd}, 40'(ir[i]));
        end
        for (int i = 0; i < 16; i++) put_mem(i, $random(seed) % 1000);
        for (int i = 0; i < 24; i++) begin
            c = $random(seed);
            c.rsvd = 8'h00;
            if (i == 0) begin
                c.par = 1'b1;
                c.src3 = c.dst;
                c.st_aux = c.s2_sel;
                c.st_disp = c.s2_disp;
            end
            if (i == 1) begin
                c = '0;
                c.s2_sel = 3'h5;
                c.s1_sel = 3'h5;
            end
            t = 32'($random(seed)) & 32'h1;
            wr(12'h008, t);
            rdw(12'h008);
            chk({8'h0, rd}, {8'h0, t});
            run(c);
        end
        put_reg(1, 1.5 * 2.0 ** 127);
        put_reg(2, -1.5 * 2.0 ** 127);
        put_reg(4, 1.5 * 2.0 ** -127);
        put_reg(5, 2.0 ** -127);
        c = '0;
        c.dst = 3'h3;
        c.s1_sel = 3'h1;
        c.s2_sel = 3'h2;
        run(c);
        c.dst = 3'h6;
        c.s1_sel = 3'h4;
        c.s2_sel = 3'h5;
        run(c);
        end_sim();
    end
endmodule
